// *** src/wwd_pkg.sv ***
// Purpose: constants and types shared by the window watchdog
// Assumes: byte addresses are four times the register index
// Notes:   slow tick timing counted in ticks of the 1 kHz source
package wwd_pkg;
  // register indexes
  localparam logic [1:0] WWD_IDX_CONTROL = 2'h0;
  localparam logic [1:0] WWD_IDX_STATE   = 2'h1;
  localparam logic [1:0] WWD_IDX_IRQ_STS = 2'h2;
  localparam logic [1:0] WWD_IDX_IRQ_MSK = 2'h3;
  // primary_control fields
  localparam int WWD_OPEN_LSB   = 0;
  localparam int WWD_CLOSED_LSB = 4;
  localparam int WWD_FIELD_W    = 4;
  // watchdog_state fields
  localparam int WWD_PEND_BIT   = 0;
  localparam int WWD_LOCK_BIT   = 7;
  // irq status fields
  localparam int WWD_EV_TIMEOUT = 0;
  localparam int WWD_EV_EARLY   = 1;
  localparam int WWD_EV_SYNCED  = 2;
  localparam int WWD_EV_W       = 3;
  // reset values
  localparam logic [7:0] WWD_CONTROL_RST = 8'h00;
  localparam logic [7:0] WWD_STATE_RST   = 8'h00;
  localparam logic [WWD_EV_W-1:0] WWD_MSK_RST = 3'h0;
  // highest valid timeout code, base shift (code 1 = 8 ticks)
  localparam logic [3:0] WWD_CODE_MAX = 4'hB;
  localparam int WWD_CODE_SHIFT = 2;
  // timing
  localparam int WWD_SYS_MHZ        = 100;
  localparam int WWD_SLOW_HZ        = 1000;
  localparam int WWD_CLR_SYNC_TICKS = 2;
  localparam int WWD_CTL_SYNC_TICKS = 2;
  localparam int WWD_GUARD_INSTR    = 4;
  localparam int WWD_GUARD_CYCLES   = WWD_GUARD_INSTR;
  typedef enum logic [2:0] {
    WWD_OFF, WWD_FIRST, WWD_NORMAL, WWD_CLOSED, WWD_OPEN
  } wwd_state_e;
endpackage : wwd_pkg

// *** src/wwd_top.sv ***
// Purpose: window watchdog with Avalon-MM slave registers
// Assumes: slow_tick_clock is a free 1 kHz square wave, sampled on clk
// Notes:   single clock design; slow edges found by a synchroniser
`timescale 1ns/1ps
module wwd_top
  import wwd_pkg::*;
#(
  parameter int CNT_W = 14
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        slow_tick_clock,
  input  wire logic        watchdog_clear_instruction,
  input  wire logic        io_protect_key,
  input  wire logic [7:0]  boot_config_fuse,
  input  wire logic        fuse_valid,
  input  wire logic        debug_halt,
  input  wire logic        reset_ack,
  output logic             sys_reset_req,
  output logic             irq
);

  // refuse counters too narrow for the longest code or needlessly wide
  if (CNT_W < 14 || CNT_W > 24) begin : g_cnt_w_bad
    $error("CNT_W must hold 8192 ticks and stay below 25 bits");
  end

  typedef struct packed {
    logic                wait_r;
    logic [31:0]         rdata_r;
    logic [7:0]          ctl_r;
    logic [7:0]          act_r;
    logic                lock_r;
    logic                pend_r;
    logic [1:0]          xcnt_r;
    logic [2:0]          guard_r;
    logic                cbusy_r;
    logic [1:0]          ccnt_r;
    wwd_state_e          st_r;
    logic [CNT_W-1:0]    cnt_r;
    logic                halt_r;
    logic [WWD_EV_W-1:0] sts_r;
    logic [WWD_EV_W-1:0] msk_r;
    logic                irq_r;
    logic                rreq_r;
    logic                t1_r;
    logic                t2_r;
    logic                t3_r;
  } wwd_regs_s;

  wwd_regs_s q_r;
  wwd_regs_s q_nxt;

  // ticks for a timeout code; zero for off or reserved codes
  function automatic logic [CNT_W-1:0] wwd_len(input logic [3:0] code);
    logic [CNT_W-1:0] v;
    v = '0;
    if (code != 4'h0 && code <= WWD_CODE_MAX) begin
      v = CNT_W'(1) << (code + 4'(WWD_CODE_SHIFT));
    end
    return v;
  endfunction

  logic [3:0]       open_code;
  logic [3:0]       closed_code;
  logic [CNT_W-1:0] open_len;
  logic [CNT_W-1:0] closed_len;
  logic             tick;
  logic             clr_apply;
  logic             wr_take;
  logic [1:0]       idx;
  logic             guard_ok;
  logic             resume;

  assign open_code   = q_r.act_r[WWD_OPEN_LSB +: WWD_FIELD_W];
  assign closed_code = q_r.act_r[WWD_CLOSED_LSB +: WWD_FIELD_W];
  assign open_len    = wwd_len(open_code);
  assign closed_len  = wwd_len(closed_code);
  // the second and third synchroniser flops feed the edge detector
  assign tick      = q_r.t2_r & ~q_r.t3_r;
  assign clr_apply = tick & q_r.cbusy_r & ~q_r.halt_r &
                     (q_r.ccnt_r == 2'(WWD_CLR_SYNC_TICKS - 1));
  assign wr_take   = avs_write & ~q_r.wait_r & avs_byteenable[0];
  assign idx       = avs_address[3:2];
  assign guard_ok  = (q_r.guard_r != 3'h0);
  assign resume    = q_r.halt_r & ~debug_halt;

  always_comb begin
    logic [CNT_W-1:0] cnt_inc;
    logic             expire;
    logic             viol_to;
    logic             viol_early;
    logic             synced;
    logic [WWD_EV_W-1:0] ev;
    cnt_inc    = q_r.cnt_r + CNT_W'(1);
    expire     = 1'b0;
    viol_to    = 1'b0;
    viol_early = 1'b0;
    synced     = 1'b0;
    ev         = '0;
    q_nxt      = q_r;
    q_nxt.t1_r = slow_tick_clock;
    q_nxt.t2_r = q_r.t1_r;
    q_nxt.t3_r = q_r.t2_r;

    // bus: waitrequest drops for exactly one cycle per request
    q_nxt.wait_r = 1'b1;
    if ((avs_read | avs_write) && q_r.wait_r) begin
      q_nxt.wait_r  = 1'b0;
      q_nxt.rdata_r = 32'h0000_0000;
      case (idx)
        WWD_IDX_CONTROL: q_nxt.rdata_r[7:0] = q_r.ctl_r;
        WWD_IDX_STATE: begin
          q_nxt.rdata_r[WWD_LOCK_BIT] = q_r.lock_r;
          q_nxt.rdata_r[WWD_PEND_BIT] = q_r.pend_r;
        end
        WWD_IDX_IRQ_STS: q_nxt.rdata_r[WWD_EV_W-1:0] = q_r.sts_r;
        WWD_IDX_IRQ_MSK: q_nxt.rdata_r[WWD_EV_W-1:0] = q_r.msk_r;
        default: q_nxt.rdata_r = 32'h0000_0000;
      endcase
    end

    // key opens a short window for one protected write
    if (io_protect_key) begin
      q_nxt.guard_r = 3'(WWD_GUARD_CYCLES);
    end else if (guard_ok) begin
      q_nxt.guard_r = q_r.guard_r - 3'h1;
    end

    if (wr_take) begin
      case (idx)
        WWD_IDX_CONTROL: begin
          // locked, unkeyed or mid-crossing writes are dropped silently
          if (guard_ok && !q_r.lock_r && !q_r.pend_r) begin
            q_nxt.ctl_r   = avs_writedata[7:0];
            q_nxt.pend_r  = 1'b1;
            q_nxt.xcnt_r  = 2'h0;
            q_nxt.guard_r = 3'h0;
          end
        end
        WWD_IDX_STATE: begin
          if (guard_ok) begin
            if (avs_writedata[WWD_LOCK_BIT]) begin
              q_nxt.lock_r = 1'b1;
            end else if (debug_halt) begin
              q_nxt.lock_r = 1'b0;
            end
            q_nxt.guard_r = 3'h0;
          end
        end
        WWD_IDX_IRQ_MSK: q_nxt.msk_r = avs_writedata[WWD_EV_W-1:0];
        default: ;
      endcase
    end

    // control value reaches the slow side after a fixed tick count
    if (q_r.pend_r && tick) begin
      if (q_r.xcnt_r == 2'(WWD_CTL_SYNC_TICKS - 1)) begin
        q_nxt.act_r  = q_r.ctl_r;
        q_nxt.pend_r = 1'b0;
        synced       = 1'b1;
      end else begin
        q_nxt.xcnt_r = q_r.xcnt_r + 2'h1;
      end
    end

    // clear instruction synchroniser; repeats while busy are dropped
    if (watchdog_clear_instruction && !q_r.cbusy_r) begin
      q_nxt.cbusy_r = 1'b1;
      q_nxt.ccnt_r  = 2'h0;
    end else if (q_r.cbusy_r && tick) begin
      if (q_r.ccnt_r == 2'(WWD_CLR_SYNC_TICKS - 1)) begin
        q_nxt.cbusy_r = 1'b0;
      end else begin
        q_nxt.ccnt_r = q_r.ccnt_r + 2'h1;
      end
    end

    // watchdog sequence, frozen and zeroed under debug halt
    q_nxt.halt_r = debug_halt;
    if (debug_halt) begin
      q_nxt.cnt_r = '0;
    end else if (resume) begin
      q_nxt.cnt_r = '0;
      if (open_code == 4'h0) begin
        q_nxt.st_r = WWD_OFF;
      end else if (closed_code != 4'h0) begin
        q_nxt.st_r = WWD_FIRST;
      end else begin
        q_nxt.st_r = WWD_NORMAL;
      end
    end else if (tick) begin
      q_nxt.cnt_r = cnt_inc;
      expire      = (cnt_inc == open_len);
      case (q_r.st_r)
        WWD_OFF: begin
          q_nxt.cnt_r = '0;
          if (open_code != 4'h0) begin
            q_nxt.st_r = (closed_code != 4'h0) ? WWD_FIRST : WWD_NORMAL;
          end
        end
        WWD_NORMAL: begin
          if (closed_code != 4'h0) begin
            q_nxt.st_r  = WWD_FIRST;
            q_nxt.cnt_r = '0;
          end else if (clr_apply) begin
            q_nxt.cnt_r = '0;
          end else if (expire) begin
            viol_to = 1'b1;
          end
        end
        WWD_FIRST: begin
          if (clr_apply) begin
            q_nxt.st_r  = WWD_CLOSED;
            q_nxt.cnt_r = '0;
          end else if (expire) begin
            viol_to = 1'b1;
          end
        end
        WWD_CLOSED: begin
          if (clr_apply) begin
            viol_early = 1'b1;
          end else if (cnt_inc == closed_len) begin
            q_nxt.st_r  = WWD_OPEN;
            q_nxt.cnt_r = '0;
          end
        end
        WWD_OPEN: begin
          if (clr_apply) begin
            q_nxt.st_r  = WWD_CLOSED;
            q_nxt.cnt_r = '0;
          end else if (expire) begin
            viol_to = 1'b1;
          end
        end
        default: q_nxt.st_r = WWD_OFF;
      endcase
      if (q_r.st_r != WWD_OFF && open_code == 4'h0) begin
        q_nxt.st_r  = WWD_OFF;
        q_nxt.cnt_r = '0;
        viol_to     = 1'b0;
        viol_early  = 1'b0;
      end
      if (q_r.st_r != WWD_OFF && open_code != 4'h0 && closed_code == 4'h0
          && q_r.st_r != WWD_NORMAL) begin
        q_nxt.st_r = WWD_NORMAL;
      end
      if (viol_to || viol_early) begin
        q_nxt.st_r  = WWD_NORMAL;
        q_nxt.cnt_r = '0;
      end
    end

    // reset request held until the controller answers
    if (viol_to || viol_early) begin
      q_nxt.rreq_r = 1'b1;
    end else if (reset_ack) begin
      q_nxt.rreq_r = 1'b0;
    end

    // boot fuse load overrides control, active value, counter and state at once
    if (fuse_valid) begin
      q_nxt.ctl_r  = boot_config_fuse;
      q_nxt.act_r  = boot_config_fuse;
      q_nxt.pend_r = 1'b0;
      q_nxt.cnt_r  = '0;
      q_nxt.st_r   = WWD_OFF;
      if (boot_config_fuse[WWD_OPEN_LSB +: WWD_FIELD_W] != 4'h0) begin
        q_nxt.lock_r = 1'b1;
      end
    end

    // sticky events: a new event wins over a write-one clear
    ev[WWD_EV_TIMEOUT] = viol_to;
    ev[WWD_EV_EARLY]   = viol_early;
    ev[WWD_EV_SYNCED]  = synced;
    if (wr_take && idx == WWD_IDX_IRQ_STS) begin
      q_nxt.sts_r = (q_r.sts_r & ~avs_writedata[WWD_EV_W-1:0]) | ev;
    end else begin
      q_nxt.sts_r = q_r.sts_r | ev;
    end
    q_nxt.irq_r = |(q_nxt.sts_r & q_nxt.msk_r);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q_r         <= '0;
      q_r.wait_r  <= 1'b1;
      q_r.ctl_r   <= WWD_CONTROL_RST;
      q_r.act_r   <= WWD_CONTROL_RST;
      q_r.lock_r  <= WWD_STATE_RST[WWD_LOCK_BIT];
      q_r.msk_r   <= WWD_MSK_RST;
      q_r.st_r    <= WWD_OFF;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign avs_readdata    = q_r.rdata_r;
  assign avs_waitrequest = q_r.wait_r;
  assign sys_reset_req   = q_r.rreq_r;
  assign irq             = q_r.irq_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_first_clear;
    q_r.st_r == WWD_FIRST && clr_apply && !debug_halt && !fuse_valid
      && open_code != 4'h0 && closed_code != 4'h0;
  endsequence
  sequence s_closed_clear;
    q_r.st_r == WWD_CLOSED && clr_apply && !debug_halt && !fuse_valid
      && open_code != 4'h0;
  endsequence

  a_wait_single: assert property (
    (avs_read | avs_write) && q_r.wait_r |=> !avs_waitrequest ##1
      avs_waitrequest)
    else $error("waitrequest not low for one cycle");
  a_first_closed: assert property (
    s_first_clear |=> q_r.st_r == WWD_CLOSED && q_r.cnt_r == '0)
    else $error("first clear did not start closed period");
  a_early_reset: assert property (
    s_closed_clear |=> sys_reset_req && q_r.sts_r[WWD_EV_EARLY])
    else $error("early clear gave no reset");
  a_reset_held: assert property (
    sys_reset_req && !reset_ack |=> sys_reset_req)
    else $error("reset request dropped before ack");
  a_halt_zero: assert property (
    debug_halt && !fuse_valid |=> q_r.cnt_r == '0 ##0 q_r.halt_r)
    else $error("counter not zero during halt");
  a_unkeyed_drop: assert property (
    wr_take && idx == WWD_IDX_CONTROL && !guard_ok && !fuse_valid
      |=> $stable(q_r.ctl_r) && !($rose(q_r.pend_r)))
    else $error("unkeyed control write took effect");
  a_locked_drop: assert property (
    q_r.lock_r && !fuse_valid |=> $stable(q_r.ctl_r))
    else $error("locked control changed");
  a_lock_sticks: assert property (
    q_r.lock_r && !debug_halt |=> q_r.lock_r)
    else $error("lock cleared outside debug");
  a_pend_set: assert property (
    wr_take && idx == WWD_IDX_CONTROL && guard_ok && !q_r.lock_r
      && !q_r.pend_r && !fuse_valid |=> q_r.pend_r [*2])
    else $error("crossing_pending not raised");
  a_fuse_lock: assert property (
    fuse_valid && boot_config_fuse[3:0] != 4'h0 |=> q_r.lock_r
      && q_r.act_r == $past(boot_config_fuse))
    else $error("fuse load did not lock");
  a_off_quiet: assert property (
    open_code == 4'h0 && q_r.st_r == WWD_OFF && !fuse_valid
      && !resume |=> q_r.st_r == WWD_OFF && q_r.cnt_r == '0)
    else $error("watchdog ran with period zero");
  a_irq_level: assert property (
    1'b1 |=> irq == |($past(q_nxt.sts_r) & $past(q_nxt.msk_r)))
    else $error("irq does not follow status and mask");

endmodule // wwd_top

// *** tb/wwd_far_end.sv ***
// Purpose: slow oscillator and reset controller beside the watchdog
// Assumes: the controller acknowledges ACK_DLY+1 clocks after a request
// Notes:   slow clock runs free and out of phase with clk
`timescale 1ns/1ps
module wwd_far_end #(
  parameter int  ACK_DLY = 5,
  parameter real HALF_NS = 43.0
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic sys_reset_req,
  output logic      reset_ack,
  output logic      slow_tick_clock
);
  int wait_q;
  initial begin
    slow_tick_clock = 1'b0;
    reset_ack       = 1'b0;
    wait_q          = 0;
    // odd offset keeps slow edges off the clk edges
    #3.7;
    forever #(HALF_NS) slow_tick_clock = ~slow_tick_clock;
  end
  // ack held until the request drops, as a real controller would
  always @(posedge clk) begin
    if (!rst_n || !sys_reset_req) begin
      wait_q    <= 0;
      reset_ack <= 1'b0;
    end else if (wait_q < ACK_DLY) begin
      wait_q <= wait_q + 1;
    end else begin
      reset_ack <= 1'b1;
    end
  end
endmodule // wwd_far_end

// *** tb/test_window_watchdog_timer.sv ***
// Purpose: register level tests of the window watchdog
// Assumes: slow tick about 8.6 clk, code 1 is 8 ticks
// Notes:   timing checks allow for the 1 to 2 tick clear sync
`timescale 1ns/1ps
module test_window_watchdog_timer
  import wwd_pkg::*;
();
  logic        clk, rst_n, avs_read, avs_write, clr, key;
  logic        fuse_valid, debug_halt, reset_ack, sys_reset_req;
  logic        irq, slow_tick_clock, avs_waitrequest, rq_q;
  logic [3:0]  avs_address;
  logic [7:0]  fuse;
  logic [31:0] avs_writedata, avs_readdata, rdv;
  int          n_errors, n_compared, n_rst, t0, lo, hi;

  wwd_top #(.CNT_W(14)) dut_u (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .slow_tick_clock(slow_tick_clock),
    .watchdog_clear_instruction(clr), .io_protect_key(key),
    .boot_config_fuse(fuse), .fuse_valid(fuse_valid),
    .debug_halt(debug_halt), .reset_ack(reset_ack),
    .sys_reset_req(sys_reset_req), .irq(irq)
  );
  wwd_far_end far_u (
    .clk(clk), .rst_n(rst_n), .sys_reset_req(sys_reset_req),
    .reset_ack(reset_ack), .slow_tick_clock(slow_tick_clock)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    rq_q <= sys_reset_req;
    if (sys_reset_req === 1'b1 && rq_q !== 1'b1) n_rst <= n_rst + 1;
  end

  task automatic close_out();
    if (n_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // entered just after a rising edge; holds until waitrequest low
  task automatic xfer(input logic rw, input logic [3:0] a,
                      input logic [7:0] d);
    int k;
    k = 0;
    avs_address   <= a;
    avs_writedata <= {24'h0, d};
    if (rw) avs_write <= 1'b1;
    else avs_read <= 1'b1;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && k < 20) begin
      k++;
      @(posedge clk);
    end
    if (k >= 20) n_errors++;
    rdv = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [3:0] a);
    xfer(1'b0, a, 8'h00);
  endtask

  task automatic key_wr(input logic [3:0] a, input logic [7:0] d);
    key <= 1'b1;
    @(posedge clk);
    key <= 1'b0;
    xfer(1'b1, a, d);
  endtask

  task automatic pulse_clr();
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic settle();
    int k;
    k = 0;
    rd(4'h4);
    while (rdv[WWD_PEND_BIT] !== 1'b0 && k < 60) begin
      k++;
      rd(4'h4);
    end
    chk(32'(rdv[WWD_PEND_BIT]), 32'h0);
  endtask

  task automatic meas(output int c);
    c = 0;
    while (sys_reset_req !== 1'b1 && c < 2000) begin
      c++;
      @(posedge clk);
    end
  endtask

  initial begin
    #600_000;
    n_errors++;
    close_out();
  end

  initial begin
    rst_n = 1'b0; avs_read = 1'b0; avs_write = 1'b0; clr = 1'b0;
    key = 1'b0; fuse_valid = 1'b0; debug_halt = 1'b0; fuse = 8'h00;
    avs_address = 4'h0; avs_writedata = 32'h0; rq_q = 1'b0;
    n_errors = 0; n_compared = 0; n_rst = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      rd(4'(i * 4));
      chk(rdv, 32'h0);
    end
    wr_plain: begin
      xfer(1'b1, 4'h0, 8'h01);
      rd(4'h0);
      chk(rdv, 32'h0);
    end
    repeat (400) @(posedge clk);
    chk(n_rst, 0);
    for (int c = 1; c <= 3; c++) begin
      key_wr(4'h0, 8'(c));
      rd(4'h4);
      chk(32'(rdv[WWD_PEND_BIT]), 32'h1);
      settle();
      rd(4'h0);
      chk(rdv, 32'(c));
      pulse_clr();
      meas(t0);
      lo = ((8 << (c - 1)) + 1) * 86 / 10 - 4;
      hi = ((8 << (c - 1)) + 4) * 86 / 10 + 4;
      chk(32'(t0 >= lo && t0 <= hi), 32'h1);
      repeat (20) @(posedge clk);
      chk(32'(sys_reset_req), 32'h0);
    end
    key_wr(4'h0, 8'h01);
    settle();
    t0 = n_rst;
    repeat (12) begin
      pulse_clr();
      repeat (30) @(posedge clk);
    end
    chk(n_rst, t0);
    key_wr(4'h0, 8'h11);
    settle();
    pulse_clr();
    repeat (115) @(posedge clk);
    t0 = n_rst;
    pulse_clr();
    pulse_clr();
    repeat (30) @(posedge clk);
    chk(n_rst, t0);
    pulse_clr();
    meas(t0);
    chk(32'(t0 < 30), 32'h1);
    rd(4'h8);
    chk(rdv, 32'h7);
    chk(32'(irq), 32'h0);
    xfer(1'b1, 4'hC, 8'h02);
    @(posedge clk);
    chk(32'(irq), 32'h1);
    key_wr(4'h0, 8'h00);
    settle();
    xfer(1'b1, 4'h8, 8'h07);
    rd(4'h8);
    chk(rdv, 32'h0);
    @(posedge clk);
    chk(32'(irq), 32'h0);
    xfer(1'b1, 4'h4, 8'h80);
    rd(4'h4);
    chk(rdv, 32'h0);
    key_wr(4'h4, 8'h80);
    rd(4'h4);
    chk(rdv, 32'h80);
    key_wr(4'h0, 8'h05);
    rd(4'h0);
    chk(rdv, 32'h0);
    key_wr(4'h4, 8'h00);
    rd(4'h4);
    chk(rdv, 32'h80);
    debug_halt <= 1'b1;
    key_wr(4'h4, 8'h00);
    rd(4'h4);
    chk(rdv, 32'h0);
    debug_halt <= 1'b0;
    fuse       <= 8'h13;
    fuse_valid <= 1'b1;
    @(posedge clk);
    fuse_valid <= 1'b0;
    @(posedge clk);
    rd(4'h0);
    chk(rdv, 32'h13);
    rd(4'h4);
    chk(32'(rdv[WWD_LOCK_BIT]), 32'h1);
    // halt longer than the 32 tick open period: no reset may follow
    debug_halt <= 1'b1;
    t0 = n_rst;
    repeat (400) @(posedge clk);
    chk(n_rst, t0);
    // resume runs one plain 32 tick timeout from zero, no closed part
    debug_halt <= 1'b0;
    meas(t0);
    lo = 32 * 86 / 10 - 4;
    hi = 34 * 86 / 10 + 4;
    chk(32'(t0 >= lo && t0 <= hi), 32'h1);
    close_out();
  end
endmodule // test_window_watchdog_timer
